// >>> ccs_defines.vh
/*
 Constants for the cache control and start-up block: control register field
 positions, reset value and cache geometry. Included by every design file.
*/
`ifndef CCS_DEFINES_VH
`define CCS_DEFINES_VH
`define CCS_CTRL_RESET 32'h0000_0000
`define CCS_BIT_DATA_CACHE_ENABLE 31
`define CCS_BIT_DEFAULT_WRITE_PROTECT 30
`define CCS_BIT_STORE_BUFFER_ENABLE 29
`define CCS_BIT_PUSH_INVALIDATE_DISABLE 28
`define CCS_BIT_DATA_INVALIDATE_ALL 24
`define CCS_BIT_INSTR_INVALIDATE_ALL 8
`define CCS_LINE_BYTES 16
`define CCS_SETS 256
`define CCS_SET_BITS 8
`define CCS_SB_DEPTH 4
`endif

// >>> ccs_way_state.v
/*
 Per-set line state for a two-way cache: valid and modified bits per way.
 Assumes the parent sequences invalidate-all, allocation and push operations.
*/
`timescale 1ns/1ps
`include "ccs_defines.vh"
module ccs_way_state #(
    parameter SETS = `CCS_SETS,
    parameter SET_BITS = `CCS_SET_BITS
) (
    // Clock.
    input wire clk,
    // Operations.
    input wire inval_all,
    input wire alloc,
    input wire [SET_BITS-1:0] alloc_set,
    input wire alloc_dirty,
    input wire push,
    input wire [SET_BITS-1:0] push_set,
    input wire push_way,
    input wire push_invalidate,
    // Lookup of the allocation set.
    output wire [1:0] set_valid,
    output wire [1:0] set_modified,
    output wire alloc_way
);
    // No reset: state bits power up in whatever value the cells take and a
    // reset leaves them alone; an invalidate-all clears them, a line push clears its modified bit
    // and, with push_invalidate set, its valid bit, and a clean allocation clears a modified bit.
    reg [1:0] valid_reg [0:SETS-1];
    reg [1:0] modified_reg [0:SETS-1];
    integer i;

    assign set_valid = valid_reg[alloc_set];
    assign set_modified = modified_reg[alloc_set];
    assign alloc_way = set_valid[0] ? 1'b1 : 1'b0; // [RL4] [RL5]

    always @(posedge clk) begin // [RL1] [RL2] [RL8]
        if (inval_all) begin
            for (i = 0; i < SETS; i = i + 1) begin
                valid_reg[i] <= 2'b00;
                modified_reg[i] <= 2'b00;
            end
        end else begin
            if (alloc) begin
                valid_reg[alloc_set][alloc_way] <= 1'b1;
                modified_reg[alloc_set][alloc_way] <= alloc_dirty;
            end
            if (push) begin
                modified_reg[push_set][push_way] <= 1'b0;
                if (push_invalidate) begin
                    valid_reg[push_set][push_way] <= 1'b0; // [RL15]
                end
            end
        end
    end
endmodule // ccs_way_state

// >>> ccs_store_buffer.v
/*
 Four-entry FIFO store buffer for deferred writes. Assumes the parent only
 pushes when not full and holds pop until bus completion.
*/
`timescale 1ns/1ps
`include "ccs_defines.vh"
module ccs_store_buffer #(
    parameter DEPTH = `CCS_SB_DEPTH,
    parameter WIDTH = 64
) (
    // Clock and reset.
    input wire clk,
    input wire arst_n,
    // Fill side.
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // Drain side.
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [2:0] count_reg;
    reg [1:0] rd_reg;
    reg [1:0] wr_reg;
    wire do_push;
    wire do_pop;

    assign in_ready = (count_reg != DEPTH[2:0]);
    assign out_valid = (count_reg != 3'h0);
    assign out_data = mem[rd_reg];
    assign do_push = in_valid && in_ready;
    assign do_pop = out_valid && out_ready;

    always @(posedge clk) begin
        if (do_push) begin
            mem[wr_reg] <= in_data;
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count_reg <= 3'h0;
            rd_reg <= 2'h0;
            wr_reg <= 2'h0;
        end else begin
            if (do_push) begin
                wr_reg <= wr_reg + 2'h1;
            end
            if (do_pop) begin
                rd_reg <= rd_reg + 2'h1;
            end
            if (do_push && !do_pop) begin
                count_reg <= count_reg + 3'h1;
            end else if (do_pop && !do_push) begin
                count_reg <= count_reg - 3'h1;
            end
        end
    end
endmodule // ccs_store_buffer

// >>> ccs_cache_control.v
/*
 Cache control register and the cache behaviour it steers: data cache
 enable, default write protect, store buffer routing, line push and fill
 way choice. Assumes requests from the core are synchronous to clk and held
 until accepted, and that the bus side holds bus_ready semantics per cycle.
*/
`timescale 1ns/1ps
`include "ccs_defines.vh"
// Notes on behaviour
// RL1: After power-up line valid and modified bits are undefined and may read set.
// RL2: Power-up and reset never invalidate lines; only an explicit invalidate does.
// RL3: Software should invalidate both caches before enabling either.
// RL4: After a full invalidate new lines fill way 0 of the set first.
// RL5: If way 0 holds a line, the new line goes into way 1.
// RL6: Core control-move writes the register; debug unit reads and writes it.
// RL7: Hardware reset clears the whole control register, disabling the caches.
// RL8: Hardware reset leaves tags, line state and data untouched.
// RL9: Bit 31 enables the data cache; cleared, no lookups or fills, state kept.
// RL10: Bit 30 write-protects unmatched accesses; such writes raise an access error.
// RL11: Bit 29 enables a four-entry FIFO store buffer for deferrable writes.
// RL12: Store buffer off: those writes go straight to the bus.
// RL13: Store buffer enable overrides mode bits; imprecise only when buffer off. Here writes are buffered only with bit 29 set.
// RL14: Precise cache-inhibited accesses always bypass the store buffer.
// RL15: Bit 28 clear: line push writes back if modified, then invalidates.
// RL16: Bit 28 set: line push writes back if modified, leaves line valid.
// RL17: Lines are 16 bytes; 4 Kbytes is 256 lines.
// RL18: Other register bits are stored and read back without further effect. Here bit 24 also starts a data invalidate-all when written set.
module ccs_cache_control #(
    parameter SET_BITS = `CCS_SET_BITS,
    parameter SETS = `CCS_SETS
) (
    // Clock and reset.
    input wire clk,
    input wire arst_n,
    // Core control-register move.
    input wire core_ctrl_write,
    input wire [31:0] core_ctrl_wdata,
    // Debug unit access.
    input wire dbg_ctrl_write,
    input wire [31:0] dbg_ctrl_wdata,
    output reg [31:0] dbg_ctrl_rdata,
    // Control field view.
    output wire data_cache_enable,
    output wire data_default_write_protect,
    output wire data_store_buffer_enable,
    output wire line_push_invalidate_disable,
    // Data access request from the core.
    input wire acc_valid,
    output wire acc_ready,
    input wire acc_write,
    input wire [31:0] acc_addr,
    input wire [31:0] acc_wdata,
    input wire acc_region_match,
    input wire acc_region_wp,
    input wire acc_cacheable,
    input wire acc_write_through,
    input wire acc_imprecise,
    input wire acc_miss,
    // Access result.
    output reg acc_error,
    output reg acc_filled,
    output reg acc_fill_way,
    output reg acc_buffered,
    // Line push request.
    input wire push_valid,
    input wire [SET_BITS-1:0] push_set,
    input wire push_way,
    output reg push_writeback,
    output reg push_done,
    // Bus write, direct or drained from the store buffer.
    output wire bus_wvalid,
    input wire bus_wready,
    output wire [31:0] bus_waddr,
    output wire [31:0] bus_wdata
);
    localparam ST_IDLE = 1'b0;
    localparam ST_DIRECT = 1'b1;

    reg [31:0] ctrl_reg;
    reg [31:0] ctrl_next;
    reg state_reg;
    reg [31:0] dir_addr_reg;
    reg [31:0] dir_data_reg;
    wire inval_all;
    wire is_write;
    wire protect_fault;
    wire defer_write;
    wire direct_write;
    wire sb_in_ready;
    wire sb_out_valid;
    wire [63:0] sb_out_data;
    wire alloc;
    wire alloc_way;
    wire [1:0] set_valid;
    wire [1:0] set_modified;
    wire [1:0] push_state_mod;
    wire accept;
    wire [SET_BITS-1:0] acc_set;
    reg route_bus;
    reg route_defer;

    assign data_cache_enable = ctrl_reg[`CCS_BIT_DATA_CACHE_ENABLE]; // [RL9]
    assign data_default_write_protect = ctrl_reg[`CCS_BIT_DEFAULT_WRITE_PROTECT];
    assign data_store_buffer_enable = ctrl_reg[`CCS_BIT_STORE_BUFFER_ENABLE];
    assign line_push_invalidate_disable = ctrl_reg[`CCS_BIT_PUSH_INVALIDATE_DISABLE];

    // Debug write wins over a core write landing in the same cycle.
    always @* begin
        ctrl_next = ctrl_reg;
        if (core_ctrl_write) begin
            ctrl_next = core_ctrl_wdata; // [RL6] [RL18]
        end
        if (dbg_ctrl_write) begin
            ctrl_next = dbg_ctrl_wdata; // [RL6]
        end
    end

    // The data invalidate-all bit (24) acts as a one-shot command on the write that sets it.
    assign inval_all = (core_ctrl_write && core_ctrl_wdata[`CCS_BIT_DATA_INVALIDATE_ALL]) ||
                       (dbg_ctrl_write && dbg_ctrl_wdata[`CCS_BIT_DATA_INVALIDATE_ALL]);

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_reg <= `CCS_CTRL_RESET; // [RL7]
            dbg_ctrl_rdata <= `CCS_CTRL_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
            dbg_ctrl_rdata <= ctrl_next; // [RL6]
        end
    end

    // Line index from address: 16-byte lines, 256 sets per way.
    assign acc_set = acc_addr[SET_BITS+3:4]; // [RL17]
    assign is_write = acc_valid && acc_write;
    assign protect_fault = is_write && !acc_region_match && data_default_write_protect; // [RL10]

    // Route table over cacheable, write-through and imprecise: which writes need a
    // bus cycle at all, and which of those the store buffer may defer.
    always @* begin
        route_bus = 1'b1;
        route_defer = 1'b1;
        case ({acc_cacheable, acc_write_through, acc_imprecise})
            3'b000: begin
                route_bus = 1'b1;
                route_defer = 1'b0; // [RL14]
            end
            3'b001: begin
                route_bus = 1'b1;
                route_defer = 1'b1; // [RL11] [RL13]
            end
            3'b010: begin
                route_bus = 1'b1;
                route_defer = 1'b0; // [RL14]
            end
            3'b011: begin
                route_bus = 1'b1;
                route_defer = 1'b1; // [RL11] [RL13]
            end
            3'b100: begin
                route_bus = 1'b0;
                route_defer = 1'b0;
            end
            3'b101: begin
                route_bus = 1'b1;
                route_defer = 1'b1; // [RL11] [RL13]
            end
            3'b110: begin
                route_bus = 1'b1;
                route_defer = 1'b1; // [RL11]
            end
            3'b111: begin
                route_bus = 1'b1;
                route_defer = 1'b1; // [RL11]
            end
            default: begin
                route_bus = 1'b1;
                route_defer = 1'b0;
            end
        endcase
    end

    assign defer_write = is_write && !protect_fault && data_store_buffer_enable && route_defer;
    assign direct_write = is_write && !protect_fault && !defer_write && route_bus; // [RL12]

    assign accept = acc_valid && acc_ready;
    // A direct write waits for the buffer to drain so it is neither lost nor ahead of
    // older writes; no access is taken during a push, which borrows the state index.
    assign acc_ready = (state_reg == ST_IDLE) && (!defer_write || sb_in_ready) &&
                       !(direct_write && sb_out_valid) && !push_valid; // [RL12]
    assign alloc = accept && !protect_fault && data_cache_enable && acc_cacheable &&
                   acc_miss && !inval_all; // [RL9]

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            acc_error <= 1'b0;
            acc_filled <= 1'b0;
            acc_fill_way <= 1'b0;
            acc_buffered <= 1'b0;
        end else begin
            acc_error <= accept && protect_fault; // [RL10]
            acc_filled <= alloc;
            acc_fill_way <= alloc ? alloc_way : acc_fill_way; // [RL4] [RL5]
            acc_buffered <= accept && defer_write;
        end
    end

    // Direct writes hold the bus path until the bus accepts; buffered ones drain
    // only while no direct write is pending, so program order stays intact.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= ST_IDLE;
            dir_addr_reg <= 32'h0000_0000;
            dir_data_reg <= 32'h0000_0000;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (accept && direct_write && !sb_out_valid) begin
                        state_reg <= ST_DIRECT; // [RL12]
                        dir_addr_reg <= acc_addr;
                        dir_data_reg <= acc_wdata;
                    end
                end
                ST_DIRECT: begin
                    if (bus_wready) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    assign bus_wvalid = (state_reg == ST_DIRECT) || sb_out_valid;
    assign bus_waddr = (state_reg == ST_DIRECT) ? dir_addr_reg : sb_out_data[63:32];
    assign bus_wdata = (state_reg == ST_DIRECT) ? dir_data_reg : sb_out_data[31:0];

    ccs_store_buffer #(
        .DEPTH(`CCS_SB_DEPTH),
        .WIDTH(64)
    ) u_store_buffer (
        .clk(clk),
        .arst_n(arst_n),
        .in_valid(accept && defer_write), // [RL11]
        .in_ready(sb_in_ready),
        .in_data({acc_addr, acc_wdata}),
        .out_valid(sb_out_valid),
        .out_ready(bus_wready && (state_reg == ST_IDLE)),
        .out_data(sb_out_data)
    );

    // Line push: write back when modified, invalidate unless bit 28 is set.
    assign push_state_mod = set_modified;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            push_writeback <= 1'b0;
            push_done <= 1'b0;
        end else begin
            push_writeback <= push_valid && push_state_mod[push_way];
            push_done <= push_valid;
        end
    end

    ccs_way_state #(
        .SETS(SETS),
        .SET_BITS(SET_BITS)
    ) u_way_state (
        .clk(clk),
        .inval_all(inval_all), // [RL2]
        .alloc(alloc),
        .alloc_set(push_valid ? push_set : acc_set),
        .alloc_dirty(acc_write && !acc_write_through),
        .push(push_valid),
        .push_set(push_set),
        .push_way(push_way),
        .push_invalidate(!line_push_invalidate_disable), // [RL15] [RL16]
        .set_valid(set_valid),
        .set_modified(set_modified),
        .alloc_way(alloc_way)
    );
endmodule // ccs_cache_control

// >>> ccs_properties.sv
/* Concurrent checks on the ports of the cache control block.
   Assumes one clock clk and an active-low asynchronous reset arst_n. */
`timescale 1ns/1ps
module ccs_properties (
    // Clock and reset.
    input wire clk,
    input wire arst_n,
    // Register access.
    input wire core_ctrl_write,
    input wire dbg_ctrl_write,
    input wire [31:0] dbg_ctrl_wdata,
    input wire [31:0] dbg_ctrl_rdata,
    input wire data_cache_enable,
    input wire data_default_write_protect,
    input wire data_store_buffer_enable,
    input wire line_push_invalidate_disable,
    // Accesses and pushes.
    input wire acc_valid,
    input wire acc_ready,
    input wire acc_write,
    input wire acc_region_match,
    input wire acc_cacheable,
    input wire acc_imprecise,
    input wire acc_error,
    input wire acc_filled,
    input wire acc_buffered,
    input wire push_valid,
    input wire push_done
);
    wire take = acc_valid && acc_ready;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_rst; $rose(arst_n) |-> dbg_ctrl_rdata == 32'h0 && !data_cache_enable; endproperty
    a_rst: assert property (p_rst) else $error("control not clear after reset");
    property p_dbg; dbg_ctrl_write |=> dbg_ctrl_rdata == $past(dbg_ctrl_wdata); endproperty
    a_dbg: assert property (p_dbg) else $error("debug write not stored");
    property p_hold; !core_ctrl_write && !dbg_ctrl_write |=> $stable(dbg_ctrl_rdata); endproperty
    a_hold: assert property (p_hold) else $error("control changed without write");
    property p_fld; {data_cache_enable, data_default_write_protect, data_store_buffer_enable,
        line_push_invalidate_disable} == dbg_ctrl_rdata[31:28]; endproperty
    a_fld: assert property (p_fld) else $error("field view differs");
    property p_wp; take && acc_write && !acc_region_match && data_default_write_protect
        |=> acc_error; endproperty
    a_wp: assert property (p_wp) else $error("protected write not faulted");
    property p_off; take && !data_cache_enable |=> !acc_filled; endproperty
    a_off: assert property (p_off) else $error("fill with cache off");
    property p_sboff; take && !data_store_buffer_enable |=> !acc_buffered; endproperty
    a_sboff: assert property (p_sboff) else $error("buffered with buffer off");
    property p_prec; take && !acc_cacheable && !acc_imprecise |=> !acc_buffered; endproperty
    a_prec: assert property (p_prec) else $error("precise inhibited buffered");
    property p_push; push_valid |=> push_done; endproperty
    a_push: assert property (p_push) else $error("push not done");
endmodule // ccs_properties
bind ccs_cache_control ccs_properties chk (.*);

// >>> ccs_bus_partner.sv
/* Bus target that accepts direct and buffered writes, fast or slow.
   Assumes bus_wvalid is held with its address until bus_wready. */
`timescale 1ns/1ps
module ccs_bus_partner (
    input wire clk,
    input wire arst_n,
    input wire slow,
    input wire bus_wvalid,
    input wire [31:0] bus_waddr,
    input wire [31:0] bus_wdata,
    output reg bus_wready,
    output reg [7:0] n_wr,
    output reg [31:0] last_addr,
    output reg [31:0] last_data
);
    reg [3:0] wait_cnt;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_wready <= 1'b0;
            wait_cnt <= 4'h0;
            n_wr <= 8'h0;
        end else if (bus_wvalid && bus_wready) begin
            bus_wready <= 1'b0;
            wait_cnt <= 4'h0;
            n_wr <= n_wr + 8'h1;
            last_addr <= bus_waddr;
            last_data <= bus_wdata;
        end else if (bus_wvalid && wait_cnt >= (slow ? 4'h5 : 4'h0)) begin
            bus_wready <= 1'b1;
        end else if (bus_wvalid) begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule // ccs_bus_partner

// >>> test_cache_control_and_startup.sv
/* Self-checking bench for the cache control block with a reference model.
   Assumes the block, its checker and the bus partner are compiled first. */
`timescale 1ns/1ps
module test_cache_control_and_startup;
    reg clk = 0;
    reg arst_n = 0;
    reg core_ctrl_write = 0, dbg_ctrl_write = 0, acc_valid = 0, push_valid = 0, push_way = 0;
    reg acc_write = 0, acc_region_match = 0, acc_region_wp = 0, acc_cacheable = 0;
    reg acc_write_through = 0, acc_imprecise = 0, acc_miss = 0, slow = 0;
    reg [31:0] core_ctrl_wdata = 0, dbg_ctrl_wdata = 0, acc_addr = 0, acc_wdata = 0, m_reg = 0;
    reg [7:0] push_set = 0, n_exp = 0;
    reg [1:0] occ [0:255];
    wire [31:0] dbg_ctrl_rdata, bus_waddr, bus_wdata, bus_last, bus_last_data;
    wire data_cache_enable, data_default_write_protect, data_store_buffer_enable;
    wire line_push_invalidate_disable, acc_ready, acc_error, acc_filled, acc_fill_way;
    wire acc_buffered, push_writeback, push_done, bus_wvalid, bus_wready;
    wire [7:0] n_bus;
    integer n_mismatch = 0, n_checks = 0, cyc = 0, i, sb;
    always #50 clk = ~clk;
    ccs_cache_control uut (.*);
    ccs_bus_partner partner (.clk(clk), .arst_n(arst_n), .slow(slow), .bus_wvalid(bus_wvalid),
        .bus_waddr(bus_waddr), .bus_wdata(bus_wdata), .bus_wready(bus_wready), .n_wr(n_bus),
        .last_addr(bus_last), .last_data(bus_last_data));
    task check(input string what, input [31:0] seen, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("Error %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task conclude;
        begin
            $display("checks %0d mismatches %0d", n_checks, n_mismatch);
            if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
            else $display("DONE - FAIL");
            $finish;
        end
    endtask
    task wr(input dbg, input [31:0] v);
        integer k;
        begin
            @(posedge clk);
            #1;
            dbg_ctrl_write = dbg;
            dbg_ctrl_wdata = v;
            core_ctrl_write = !dbg;
            core_ctrl_wdata = v;
            @(posedge clk);
            #1;
            dbg_ctrl_write = 0;
            core_ctrl_write = 0;
            m_reg = v;
            if (v[24]) for (k = 0; k < 256; k = k + 1) occ[k] = 2'b00;
            check("control", dbg_ctrl_rdata, m_reg);
        end
    endtask
    task acc(input [7:0] s, input [5:0] f);
        reg [31:0] a;
        reg err, fil, bf, bw;
        integer k;
        begin
            a = $urandom;
            a[11:0] = {s, 4'h0};
            err = f[5] && !f[4] && m_reg[30];
            fil = m_reg[31] && f[3] && f[0] && !err;
            bf = f[5] && m_reg[29] && (f[2] || f[1]) && (f[3] || f[1]) && !err;
            bw = bf || (f[5] && !err && (f[2] || f[1] || !f[3]));
            @(posedge clk);
            #1;
            {acc_write, acc_region_match, acc_cacheable, acc_write_through, acc_imprecise,
                acc_miss} = f;
            acc_addr = a;
            acc_wdata = $urandom;
            acc_valid = 1;
            k = 0;
            @(negedge clk);
            while (acc_ready !== 1'b1 && k < 50) begin
                k = k + 1;
                @(negedge clk);
            end
            check("ready", acc_ready, 1'b1);
            @(posedge clk);
            #1;
            acc_valid = 0;
            check("result", {acc_error, acc_filled, acc_buffered}, {err, fil, bf});
            if (fil) begin
                check("fill way", acc_fill_way, occ[s][0]);
                occ[s] = occ[s] | (occ[s][0] ? 2'b10 : 2'b01);
            end
            if (bw) begin
                n_exp = n_exp + 8'h1;
                k = 0;
                while (n_bus !== n_exp && k < 100) begin
                    k = k + 1;
                    @(posedge clk);
                    #1;
                end
                check("bus writes", n_bus, n_exp);
                check("bus addr", bus_last, a);
                check("bus data", bus_last_data, acc_wdata);
            end
        end
    endtask
    task push(input [7:0] s, input w, input wb);
        begin
            @(posedge clk);
            #1;
            push_valid = 1;
            push_set = s;
            push_way = w;
            @(posedge clk);
            #1;
            push_valid = 0;
            if (!m_reg[28]) occ[s][w] = 1'b0;
            check("push", {push_done, push_writeback}, {1'b1, wb});
        end
    endtask
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            n_mismatch = n_mismatch + 1;
            conclude;
        end
    end
    initial begin
        void'($urandom(72733));
        repeat (20) @(posedge clk);
        #1 arst_n = 1;
        check("reset value", dbg_ctrl_rdata, 32'h0);
        for (i = 0; i < 8; i = i + 1) wr(i[0], $urandom);
        wr(1'b0, 32'h8100_0100);
        acc(8'h05, 6'b001001);
        acc(8'h05, 6'b001001);
        acc(8'h06, 6'b001001);
        @(posedge clk);
        #1 arst_n = 0;
        m_reg = 0;
        n_exp = 0;
        @(posedge clk);
        #1 arst_n = 1;
        check("reset value", dbg_ctrl_rdata, 32'h0);
        wr(1'b1, 32'h8000_0000);
        acc(8'h06, 6'b001001);
        wr(1'b0, 32'h0);
        acc(8'h07, 6'b001001);
        wr(1'b0, 32'h4000_0000);
        acc(8'h10, 6'b101000);
        acc(8'h10, 6'b110100);
        acc(8'h10, 6'b001000);
        for (sb = 0; sb < 2; sb = sb + 1) begin
            wr(sb[0], {2'b00, sb[0], 29'h0});
            for (i = 0; i < 8; i = i + 1) begin
                slow = i[0];
                acc(8'h20, {2'b11, i[2:0], 1'b0});
            end
        end
        wr(1'b0, 32'h8000_0000);
        acc(8'h09, 6'b111001);
        wr(1'b1, 32'h9000_0000);
        push(8'h09, 1'b0, 1'b1);
        push(8'h09, 1'b0, 1'b0);
        acc(8'h09, 6'b001001);
        wr(1'b0, 32'h8000_0000);
        push(8'h09, 1'b0, 1'b0);
        acc(8'h09, 6'b001001);
        conclude;
    end
endmodule // test_cache_control_and_startup
